// ---- core/cble_consts.svh ----
// Constants for the compare, branch and load execute block.
// Assumes inclusion by bare name from the core module.
`ifndef CBLE_CONSTS_SVH
`define CBLE_CONSTS_SVH

// Register port offsets
`define CBLE_REG_CTRL      8'h00
`define CBLE_REG_FLAGS     8'h01
`define CBLE_REG_PC_LO     8'h02
`define CBLE_REG_PC_HI     8'h03
`define CBLE_REG_STAT      8'h04
`define CBLE_REG_GPR_BASE  8'h20
`define CBLE_REG_GPR_MASK  8'hE0

// Field positions
`define CBLE_CTRL_RUN      0
`define CBLE_STAT_BUSY     0
`define CBLE_STAT_RUN      1

// Status flag bit positions
`define CBLE_FLAG_C        3'd0
`define CBLE_FLAG_Z        3'd1
`define CBLE_FLAG_N        3'd2
`define CBLE_FLAG_V        3'd3
`define CBLE_FLAG_S        3'd4
`define CBLE_FLAG_H        3'd5
`define CBLE_FLAG_T        3'd6
`define CBLE_FLAG_I        3'd7

// Reset values
`define CBLE_CTRL_RESET    1'b0
`define CBLE_FLAGS_RESET   8'h00

// Pointer pair low-byte register indices
`define CBLE_PTR_X_LO      5'h1A
`define CBLE_PTR_Y_LO      5'h1C
`define CBLE_PTR_Z_LO      5'h1E

// Extra cycles after the accepting cycle
`define CBLE_STALL_BRANCH  2'd1
`define CBLE_STALL_SKIP1   2'd1
`define CBLE_STALL_SKIP2   2'd2

`endif

// ---- core/cble_pkg.sv ----
// Types for the compare, branch and load execute block.
// Assumes nothing beyond a SystemVerilog compiler.
package cble_pkg;

  // Decoded operation presented by the fetch stage
  typedef enum logic [5:0] {
    other_op, compare_skip_equal, compare_regs, compare_regs_with_carry,
    compare_immediate, skip_reg_bit_clear, skip_reg_bit_set,
    skip_io_bit_clear, skip_io_bit_set, branch_status_set,
    branch_status_clear, branch_equal, branch_not_equal, branch_carry_set,
    branch_carry_clear, branch_same_or_higher, branch_lower, branch_minus,
    branch_plus, branch_signed_ge, branch_signed_lt, branch_half_carry_set,
    branch_half_carry_clear, branch_transfer_bit_set,
    branch_transfer_bit_clear, branch_overflow_set, branch_irq_enabled,
    branch_irq_disabled, register_move, register_pair_copy, load_immediate,
    load_indirect, load_displaced
  } cble_op_t;

  // Pointer pair selection
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} cble_ptr_t;

  // Pointer addressing mode
  typedef enum logic [1:0] {addr_plain, addr_post_inc, addr_pre_dec} cble_mode_t;

  // Sequencer states
  typedef enum logic [1:0] {st_exec, st_stall, st_load} cble_state_t;

endpackage

// ---- core/cble_core.sv ----
// Execute block for compares, skips, relative branches, moves and loads.
// Assumes a fetch stage presenting decoded instructions at pc, a data
// memory that answers combinationally in the cycle its strobe is high,
// and an I/O space read combinationally by address.
//
// Our own choices: the plain strobed port and the register addresses.
`include "cble_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cble_core #(
  parameter int PC_W = 16,                        // Program counter width
  parameter int DA_W = 16                         // Data address width
) (
  input  wire logic              clk_sys,         // Core clock, 200 MHz
  input  wire logic              rstn,            // Async reset, active low
  // Decoded instruction from fetch
  input  wire logic              instr_valid,     // Instruction present
  output logic                   instr_ready,     // Instruction taken
  input  wire cble_pkg::cble_op_t instr_op,       // Operation
  input  wire logic [4:0]        instr_d,         // Destination / I/O address
  input  wire logic [4:0]        instr_r,         // Source register
  input  wire logic [2:0]        instr_bit,       // Bit or flag select
  input  wire logic [7:0]        instr_imm,       // Immediate operand
  input  wire logic [6:0]        instr_off,       // Signed branch offset
  input  wire logic [5:0]        instr_disp,      // Load displacement
  input  wire cble_pkg::cble_ptr_t  instr_ptr,    // Pointer pair
  input  wire cble_pkg::cble_mode_t instr_mode,   // Pointer mode
  input  wire logic              next_two_word,   // Following instr is 2 words
  output logic [PC_W-1:0]        pc,              // Program counter
  // Data memory read port
  output logic [DA_W-1:0]        dmem_addr,       // Read address
  output logic                   dmem_rd,         // Read strobe
  input  wire logic [7:0]        dmem_rdata,      // Data in strobe cycle
  // I/O bit test port
  output logic [4:0]             io_addr,         // I/O location
  input  wire logic [7:0]        io_rdata,        // I/O contents
  // Register port
  input  wire logic [7:0]        reg_addr,        // Register offset
  input  wire logic [7:0]        reg_wdata,       // Write data
  input  wire logic              reg_wr,          // Write strobe
  input  wire logic              reg_rd,          // Read strobe
  output logic [7:0]             reg_rdata        // Read data, next cycle
);

  // Parameter sanity: the offset extension needs PC_W of 8 or more, and
  // pointer arithmetic is fixed at a 16-bit data address
  if (PC_W < 8 || PC_W > 32 || DA_W != 16) begin : g_bad_width
    $error("cble_core: unsupported PC_W or DA_W");
  end

  // Working registers and status
  logic [7:0]            gpr [32];        // General purpose registers
  logic [7:0]            flags;           // Status flags register
  logic                  run;             // Software run enable
  cble_pkg::cble_state_t state;           // Sequencer state
  logic [1:0]            stall_cnt;       // Extra cycles left
  logic [4:0]            load_dst;        // Register awaiting load data

  // Combinational decode results
  logic                  accept;          // Instruction taken this cycle
  logic [7:0]            rd_val;          // Destination operand
  logic [7:0]            rr_val;          // Source operand
  logic [7:0]            sub_b;           // Subtrahend
  logic                  sub_cin;         // Borrow in
  logic [8:0]            sub_res;         // Difference with borrow
  logic                  is_cmp;          // Compare family
  logic                  do_skip;         // Skip condition met
  logic                  is_skip;         // Skip family
  logic                  is_branch;       // Branch family
  logic                  do_branch;       // Branch condition met
  logic                  is_load;         // Load family
  logic [4:0]            ptr_lo;          // Pointer low register index
  logic [15:0]           ptr_val;         // Pointer contents
  logic [15:0]           next_ptr;        // Updated pointer
  logic [DA_W-1:0]       ld_addr;         // Effective load address
  logic [PC_W-1:0]       next_pc;         // Program counter after instr
  logic [PC_W-1:0]       off_ext;         // Sign-extended offset
  logic [7:0]            next_flags;      // Flags after compare

  // Pointer pair low index
  function automatic logic [4:0] ptr_index(input cble_pkg::cble_ptr_t sel);
    unique case (sel)
      cble_pkg::ptr_x: ptr_index = `CBLE_PTR_X_LO;
      cble_pkg::ptr_y: ptr_index = `CBLE_PTR_Y_LO;
      cble_pkg::ptr_z: ptr_index = `CBLE_PTR_Z_LO;
      default:         ptr_index = `CBLE_PTR_Z_LO;  // Unused code
    endcase
  endfunction

  // Branch condition from operation and current flags
  function automatic logic branch_cond(input cble_pkg::cble_op_t op,
                                       input logic [2:0] sel,
                                       input logic [7:0] f);
    branch_cond = 1'b0;
    unique case (op)
      cble_pkg::branch_status_set:         branch_cond = f[sel];
      cble_pkg::branch_status_clear:       branch_cond = ~f[sel];
      cble_pkg::branch_equal:              branch_cond = f[`CBLE_FLAG_Z];
      cble_pkg::branch_not_equal:          branch_cond = ~f[`CBLE_FLAG_Z];
      cble_pkg::branch_carry_set,
      cble_pkg::branch_lower:              branch_cond = f[`CBLE_FLAG_C];
      cble_pkg::branch_carry_clear,
      cble_pkg::branch_same_or_higher:     branch_cond = ~f[`CBLE_FLAG_C];
      cble_pkg::branch_minus:              branch_cond = f[`CBLE_FLAG_N];
      cble_pkg::branch_plus:               branch_cond = ~f[`CBLE_FLAG_N];
      cble_pkg::branch_signed_ge:
        branch_cond = ~(f[`CBLE_FLAG_N] ^ f[`CBLE_FLAG_V]);
      cble_pkg::branch_signed_lt:
        branch_cond = f[`CBLE_FLAG_N] ^ f[`CBLE_FLAG_V];
      cble_pkg::branch_half_carry_set:     branch_cond = f[`CBLE_FLAG_H];
      cble_pkg::branch_half_carry_clear:   branch_cond = ~f[`CBLE_FLAG_H];
      cble_pkg::branch_transfer_bit_set:   branch_cond = f[`CBLE_FLAG_T];
      cble_pkg::branch_transfer_bit_clear: branch_cond = ~f[`CBLE_FLAG_T];
      cble_pkg::branch_overflow_set:       branch_cond = f[`CBLE_FLAG_V];
      cble_pkg::branch_irq_enabled:        branch_cond = f[`CBLE_FLAG_I];
      cble_pkg::branch_irq_disabled:       branch_cond = ~f[`CBLE_FLAG_I];
      default:                             branch_cond = 1'b0;
    endcase
  endfunction

  // Handshake: take instructions only when running and idle
  assign instr_ready = run && (state == cble_pkg::st_exec);
  assign accept      = instr_valid && instr_ready;
  assign io_addr     = instr_d;

  // Operand fetch, compare arithmetic and control decisions
  always_comb begin
    rd_val  = gpr[instr_d];
    rr_val  = gpr[instr_r];
    is_cmp  = (instr_op == cble_pkg::compare_regs) ||
              (instr_op == cble_pkg::compare_regs_with_carry) ||
              (instr_op == cble_pkg::compare_immediate);
    sub_b   = (instr_op == cble_pkg::compare_immediate) ? instr_imm : rr_val;
    // Carry variant also subtracts the carry flag
    sub_cin = (instr_op == cble_pkg::compare_regs_with_carry) &&
              flags[`CBLE_FLAG_C];
    sub_res = {1'b0, rd_val} - {1'b0, sub_b} - {8'h00, sub_cin};
    // Flags after compare; S, T and I are kept
    next_flags = flags;
    next_flags[`CBLE_FLAG_C] = sub_res[8];
    next_flags[`CBLE_FLAG_N] = sub_res[7];
    next_flags[`CBLE_FLAG_Z] = (sub_res[7:0] == 8'h00) &&
      ((instr_op != cble_pkg::compare_regs_with_carry) || flags[`CBLE_FLAG_Z]);
    next_flags[`CBLE_FLAG_V] = (rd_val[7] & ~sub_b[7] & ~sub_res[7]) |
                               (~rd_val[7] & sub_b[7] & sub_res[7]);
    next_flags[`CBLE_FLAG_H] = (~rd_val[3] & sub_b[3]) | (sub_b[3] & sub_res[3]) |
                               (sub_res[3] & ~rd_val[3]);
    // Skip family
    is_skip = 1'b1;
    do_skip = 1'b0;
    unique case (instr_op)
      cble_pkg::compare_skip_equal: do_skip = (rd_val == rr_val);
      cble_pkg::skip_reg_bit_clear: do_skip = ~rr_val[instr_bit];
      cble_pkg::skip_reg_bit_set:   do_skip = rr_val[instr_bit];
      cble_pkg::skip_io_bit_clear:  do_skip = ~io_rdata[instr_bit];
      cble_pkg::skip_io_bit_set:    do_skip = io_rdata[instr_bit];
      default:                      is_skip = 1'b0;
    endcase
    // Branch family
    do_branch = branch_cond(instr_op, instr_bit, flags);
    is_branch = (instr_op >= cble_pkg::branch_status_set) &&
                (instr_op <= cble_pkg::branch_irq_disabled);
    // Pointer addressing
    is_load = (instr_op == cble_pkg::load_indirect) ||
              (instr_op == cble_pkg::load_displaced);
    ptr_lo  = ptr_index(instr_ptr);
    ptr_val = {gpr[ptr_lo + 5'd1], gpr[ptr_lo]};
    next_ptr = ptr_val;
    ld_addr  = ptr_val;
    if (instr_op == cble_pkg::load_displaced) begin
      // Pointer plus displacement, pointer left alone
      ld_addr = ptr_val + {10'h000, instr_disp};
    end else if (instr_mode == cble_pkg::addr_pre_dec) begin
      // Decrement before the access
      next_ptr = ptr_val - 16'h0001;
      ld_addr  = next_ptr;
    end else if (instr_mode == cble_pkg::addr_post_inc) begin
      // Increment after the access
      next_ptr = ptr_val + 16'h0001;
    end
    // Program counter selection
    off_ext = {{(PC_W-7){instr_off[6]}}, instr_off};
    if (is_branch && do_branch) begin
      next_pc = pc + off_ext + {{(PC_W-1){1'b0}}, 1'b1};
    end else if (is_skip && do_skip) begin
      next_pc = pc + (next_two_word ? PC_W'(3) : PC_W'(2));
    end else begin
      next_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end

  // Sequencer: extra cycles for taken branches, skips and loads
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state     <= cble_pkg::st_exec;
      stall_cnt <= 2'd0;
    end else begin
      unique case (state)
        cble_pkg::st_exec: begin
          if (accept && is_load) begin
            state <= cble_pkg::st_load;
          end else if (accept && is_branch && do_branch) begin
            state     <= cble_pkg::st_stall;
            stall_cnt <= `CBLE_STALL_BRANCH;
          end else if (accept && is_skip && do_skip) begin
            state     <= cble_pkg::st_stall;
            stall_cnt <= next_two_word ? `CBLE_STALL_SKIP2 : `CBLE_STALL_SKIP1;
          end
        end
        cble_pkg::st_stall: begin
          // Count down the flushed cycles
          stall_cnt <= stall_cnt - 2'd1;
          if (stall_cnt == 2'd1) begin
            state <= cble_pkg::st_exec;
          end
        end
        cble_pkg::st_load: begin
          // Second load cycle: data written, back to execute
          state <= cble_pkg::st_exec;
        end
        default: state <= cble_pkg::st_exec;
      endcase
    end
  end

  // Program counter update on every accepted instruction
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc <= '0;
    end else if (accept) begin
      pc <= next_pc;
    end
  end

  // Data memory request, held for the load's second cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dmem_rd   <= 1'b0;
      dmem_addr <= '0;
      load_dst  <= 5'd0;
    end else begin
      dmem_rd <= accept && is_load;
      if (accept && is_load) begin
        dmem_addr <= ld_addr;
        load_dst  <= instr_d;
      end
    end
  end

  // Status flags: compares update, else register port writes; other instructions leave them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags <= `CBLE_FLAGS_RESET;
    end else if (accept && is_cmp) begin
      flags <= next_flags;
    end else if (reg_wr && reg_addr == `CBLE_REG_FLAGS) begin
      flags <= reg_wdata;
    end
  end

  // Run control
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run <= `CBLE_CTRL_RESET;
    end else if (reg_wr && reg_addr == `CBLE_REG_CTRL) begin
      run <= reg_wdata[`CBLE_CTRL_RUN];
    end
  end

  // Register file writes; core writes win over the register port
  always_ff @(posedge clk_sys) begin
    if (reg_wr && (reg_addr & `CBLE_REG_GPR_MASK) == `CBLE_REG_GPR_BASE) begin
      gpr[reg_addr[4:0]] <= reg_wdata;
    end
    if (accept) begin
      unique case (instr_op)
        cble_pkg::register_move:  gpr[instr_d] <= rr_val;
        cble_pkg::load_immediate: gpr[instr_d] <= instr_imm;
        cble_pkg::register_pair_copy: begin
          // Both bytes of the pair move together
          gpr[{instr_d[4:1], 1'b0}] <= gpr[{instr_r[4:1], 1'b0}];
          gpr[{instr_d[4:1], 1'b1}] <= gpr[{instr_r[4:1], 1'b1}];
        end
        cble_pkg::load_indirect: begin
          // Pointer write-back for post-inc and pre-dec
          if (instr_mode != cble_pkg::addr_plain) begin
            gpr[ptr_lo]         <= next_ptr[7:0];
            gpr[ptr_lo + 5'd1]  <= next_ptr[15:8];
          end
        end
        default: ;
      endcase
    end
    if (state == cble_pkg::st_load) begin
      gpr[load_dst] <= dmem_rdata;
    end
  end

  // Register port read, data valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if ((reg_addr & `CBLE_REG_GPR_MASK) == `CBLE_REG_GPR_BASE) begin
        reg_rdata <= gpr[reg_addr[4:0]];
      end else begin
        unique case (reg_addr)
          `CBLE_REG_CTRL:  reg_rdata <= {7'h00, run};
          `CBLE_REG_FLAGS: reg_rdata <= flags;
          `CBLE_REG_PC_LO: reg_rdata <= 8'(pc);
          `CBLE_REG_PC_HI: reg_rdata <= 8'(pc >> 8);
          `CBLE_REG_STAT:  reg_rdata <= {6'h00, run, state != cble_pkg::st_exec};
          default:         reg_rdata <= 8'h00;  // Unmapped reads zero
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // cble_core

`default_nettype wire

// ---- verif/cble_properties.sv ----
// Checker for the execute block, bound to its top module.
// Assumes one clock domain and reset released synchronously.
`timescale 1ns/1ps
`default_nettype none
module cble_properties #(
  parameter int PC_W = 16  // Program counter width
) (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               instr_valid,
  input wire logic               instr_ready,
  input wire cble_pkg::cble_op_t instr_op,
  input wire logic [4:0]         instr_d,
  input wire logic [2:0]         instr_bit,
  input wire logic [6:0]         instr_off,
  input wire logic               next_two_word,
  input wire logic [PC_W-1:0]    pc,
  input wire logic               dmem_rd,
  input wire logic [4:0]         io_addr,
  input wire logic [7:0]         io_rdata
);
  logic            acc;    // Instruction taken this edge
  logic            is_br;  // Relative branch
  logic            is_sk;  // Skip of any kind
  logic            is_ld;  // Data memory load
  logic            is_one; // Single cycle operation
  logic [PC_W-1:0] koff;   // Sign extended offset
  assign acc = instr_valid && instr_ready;
  assign is_br = instr_op inside {[cble_pkg::branch_status_set:cble_pkg::branch_irq_disabled]};
  assign is_sk = instr_op inside {[cble_pkg::skip_reg_bit_clear:cble_pkg::skip_io_bit_set],
                                  cble_pkg::compare_skip_equal};
  assign is_ld = instr_op inside {cble_pkg::load_indirect, cble_pkg::load_displaced};
  assign is_one = instr_op inside {[cble_pkg::compare_regs:cble_pkg::compare_immediate],
                  cble_pkg::register_move, cble_pkg::register_pair_copy, cble_pkg::load_immediate};
  assign koff = {{(PC_W-7){instr_off[6]}}, instr_off};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Program counter sums are cut to PC_W so that wrap-around compares right
  a_one_cycle_op: assert property (acc && is_one |=>
    instr_ready && pc == PC_W'($past(pc) + 1))
    else $error("single cycle op took longer or moved pc wrongly");
  a_branch_timing: assert property (acc && is_br |=>
    (instr_ready && pc == PC_W'($past(pc) + 1)) or
    (!instr_ready && pc == PC_W'($past(pc) + $past(koff) + 1) ##1 instr_ready))
    else $error("branch target or cycle count wrong");
  a_skip_range: assert property (acc && is_sk |=> PC_W'(pc - $past(pc)) inside {1, 2, 3})
    else $error("skip moved pc outside one to three");
  a_skip_two_wait: assert property (acc && is_sk ##1 pc == PC_W'($past(pc) + 2) |->
    !instr_ready ##1 instr_ready) else $error("one word skip stall wrong");
  a_skip_three_wait: assert property (acc && is_sk ##1 pc == PC_W'($past(pc) + 3) |->
    !instr_ready [*2] ##1 instr_ready) else $error("two word skip stall wrong");
  a_io_set_skip: assert property (acc && instr_op == cble_pkg::skip_io_bit_set &&
    io_rdata[instr_bit] && !next_two_word |=> pc == PC_W'($past(pc) + 2))
    else $error("set I/O bit did not skip");
  a_io_clear_skip: assert property (acc && instr_op == cble_pkg::skip_io_bit_clear &&
    !io_rdata[instr_bit] && next_two_word |=> pc == PC_W'($past(pc) + 3))
    else $error("clear I/O bit did not skip two words");
  a_io_addr_follow: assert property (io_addr == instr_d)
    else $error("I/O address not from instruction");
  a_load_two_cyc: assert property (acc && is_ld |=> dmem_rd && !instr_ready ##1
    !dmem_rd && instr_ready) else $error("load strobe or length wrong");
  a_pc_hold_idle: assert property (!acc |=> $stable(pc))
    else $error("pc moved without an accepted instruction");
  c_branch_taken: cover property (acc && is_br ##1 !instr_ready);
  c_skip_three: cover property (acc && is_sk ##1 !instr_ready [*2]);
  c_load_done: cover property (acc && is_ld ##2 instr_ready);
endmodule // cble_properties
`default_nettype wire

// ---- verif/compare_branch_load_execute_bench.sv ----
// Self-checking bench for the execute block.
// Assumes package, core and checker compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module compare_branch_load_execute_bench;
  logic                 clk_sys = 1'b0;  // Core clock
  logic                 rstn    = 1'b0;  // Reset, active low
  logic                 instr_valid, next_two_word, instr_ready, dmem_rd, reg_wr, reg_rd;
  logic [4:0]           instr_d, instr_r, io_addr;
  logic [2:0]           instr_bit;
  logic [7:0]           instr_imm, dmem_rdata, io_rdata, reg_addr, reg_wdata, reg_rdata;
  logic [6:0]           instr_off;
  logic [5:0]           instr_disp;
  logic [15:0]          pc, dmem_addr, da;
  cble_pkg::cble_op_t   instr_op;
  cble_pkg::cble_ptr_t  instr_ptr;
  cble_pkg::cble_mode_t instr_mode;
  int                   failures = 0, checked = 0, cycles = 0;
  logic [7:0]           fl_pat [4] = '{8'h00, 8'hFF, 8'h08, 8'h55};  // Flag patterns for branches
  cble_core dut_u (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_op(instr_op), .instr_d(instr_d), .instr_r(instr_r),
    .instr_bit(instr_bit), .instr_imm(instr_imm), .instr_off(instr_off),
    .instr_disp(instr_disp), .instr_ptr(instr_ptr), .instr_mode(instr_mode),
    .next_two_word(next_two_word), .pc(pc), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_rdata(io_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Clock at 200 MHz
  initial forever #2.5 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk_sys);
  endtask
  task automatic put(input cble_pkg::cble_op_t o, input logic [4:0] d, input logic [4:0] r);
    instr_op <= o;
    instr_d <= d;
    instr_r <= r;
  endtask
  // One instruction: pc step and cycles until ready again
  task automatic issue(input logic [15:0] dpc, input logic [15:0] ncyc);
    logic [15:0] p0;
    logic [15:0] n;
    instr_valid <= 1'b1;
    #1 p0 = pc;
    chk("instr_ready", 16'h0001, {15'h0, instr_ready});
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    n = 16'h0001;
    #1 if (dmem_rd === 1'b1) da = dmem_addr;
    while (instr_ready !== 1'b1 && n < 16'h0008) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("pc", p0 + dpc, pc);
    chk("cycles", ncyc, n);
    @(posedge clk_sys);
  endtask
  // Branch outcome from flags
  function automatic logic taken(cble_pkg::cble_op_t o, logic [7:0] f, logic [2:0] b);
    int   ix [19] = '{9, 9, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6, 3, 7, 7};
    bit   pol [19] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 1, 0};
    logic [8:0] fx;
    int   j;
    fx = {f[2] ^ f[3], f};
    j = int'(o) - int'(cble_pkg::branch_status_set);
    return ((ix[j] == 9) ? f[b] : fx[ix[j]]) == pol[j];
  endfunction
  task automatic sk(cble_pkg::cble_op_t o, logic [2:0] b, logic t, logic [15:0] n);
    put(o, 5'd3, 5'd4);
    instr_bit <= b;
    next_two_word <= t;
    issue(n, n);
  endtask
  task automatic ld(cble_pkg::cble_op_t o, cble_pkg::cble_ptr_t p, cble_pkg::cble_mode_t m,
                    logic [5:0] q, logic [15:0] a, logic [7:0] v);
    put(o, 5'd10, 5'd0);
    instr_ptr <= p;
    instr_mode <= m;
    instr_disp <= q;
    dmem_rdata <= v;
    da = 16'h0000;
    issue(16'h0001, 16'h0002);
    chk("dmem_addr", a, da);
    dmem_rdata <= ~v;
    rd(8'h2A, v);
  endtask
  initial begin
    {instr_valid, next_two_word, reg_wr, reg_rd} = 4'h0;
    {instr_d, instr_r, instr_bit, instr_imm, instr_off, instr_disp} = '0;
    {dmem_rdata, io_rdata, reg_addr, reg_wdata} = '0;
    {instr_op, instr_ptr, instr_mode} = '0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    // Halted after reset, registers at reset values
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h04, 8'h02);
    // Compares: flags set, S and T kept
    wr(8'h21, 8'h10);
    wr(8'h22, 8'h20);
    wr(8'h25, 8'h0F);
    wr(8'h01, 8'h50);
    put(cble_pkg::compare_regs, 5'd1, 5'd2);
    issue(16'h0001, 16'h0001);
    rd(8'h01, 8'h55);
    instr_op <= cble_pkg::compare_immediate;
    instr_imm <= 8'h10;
    issue(16'h0001, 16'h0001);
    rd(8'h01, 8'h52);
    wr(8'h01, 8'h03);
    put(cble_pkg::compare_regs_with_carry, 5'd1, 5'd5);
    issue(16'h0001, 16'h0001);
    rd(8'h01, 8'h22);
    // Every branch under four flag patterns, backward offset
    instr_off <= 7'h7E;
    foreach (fl_pat[k]) begin
      for (int i = 9; i <= 27; i++) begin
        wr(8'h01, fl_pat[k]);
        put(cble_pkg::cble_op_t'(i), 5'd0, 5'd0);
        instr_bit <= 3'(i + k);
        if (taken(cble_pkg::cble_op_t'(i), fl_pat[k], 3'(i + k))) begin
          issue(16'hFFFF, 16'h0002);
        end else begin
          issue(16'h0001, 16'h0001);
        end
      end
    end
    rd(8'h01, 8'h55);
    // Skips, one and two word followers
    wr(8'h23, 8'h24);
    wr(8'h24, 8'h24);
    io_rdata <= 8'h80;
    sk(cble_pkg::skip_reg_bit_set, 3'd2, 1'b0, 16'h0002);
    sk(cble_pkg::skip_reg_bit_set, 3'd0, 1'b1, 16'h0001);
    sk(cble_pkg::skip_reg_bit_clear, 3'd0, 1'b1, 16'h0003);
    sk(cble_pkg::skip_reg_bit_clear, 3'd5, 1'b0, 16'h0001);
    sk(cble_pkg::skip_io_bit_set, 3'd7, 1'b1, 16'h0003);
    sk(cble_pkg::skip_io_bit_clear, 3'd7, 1'b0, 16'h0001);
    sk(cble_pkg::skip_io_bit_clear, 3'd0, 1'b0, 16'h0002);
    sk(cble_pkg::compare_skip_equal, 3'd0, 1'b1, 16'h0003);
    wr(8'h24, 8'h25);
    sk(cble_pkg::compare_skip_equal, 3'd0, 1'b0, 16'h0001);
    rd(8'h01, 8'h55);
    // Moves and immediate load
    put(cble_pkg::register_move, 5'd6, 5'd1);
    issue(16'h0001, 16'h0001);
    put(cble_pkg::load_immediate, 5'd7, 5'd0);
    instr_imm <= 8'hC3;
    issue(16'h0001, 16'h0001);
    put(cble_pkg::register_pair_copy, 5'd8, 5'd6);
    issue(16'h0001, 16'h0001);
    rd(8'h28, 8'h10);
    rd(8'h29, 8'hC3);
    rd(8'h01, 8'h55);
    // Pointer loads: X 0x0200, Y 0x0100, Z 0x0300
    wr(8'h3B, 8'h02);
    wr(8'h3D, 8'h01);
    wr(8'h3F, 8'h03);
    wr(8'h3A, 8'h00);
    wr(8'h3C, 8'h00);
    wr(8'h3E, 8'h00);
    ld(cble_pkg::load_indirect, cble_pkg::ptr_y, cble_pkg::addr_post_inc, 6'h00, 16'h0100, 8'h5A);
    rd(8'h3C, 8'h01);
    ld(cble_pkg::load_indirect, cble_pkg::ptr_x, cble_pkg::addr_pre_dec, 6'h00, 16'h01FF, 8'hA6);
    rd(8'h3A, 8'hFF);
    ld(cble_pkg::load_indirect, cble_pkg::ptr_z, cble_pkg::addr_plain, 6'h00, 16'h0300, 8'h96);
    rd(8'h3E, 8'h00);
    ld(cble_pkg::load_displaced, cble_pkg::ptr_z, cble_pkg::addr_plain, 6'h3F, 16'h033F, 8'h3C);
    rd(8'h3E, 8'h00);
    rd(8'h01, 8'h55);
    wrap_up();
  end
endmodule // compare_branch_load_execute_bench
bind cble_core cble_properties #(.PC_W(PC_W)) chk_u (.clk_sys(clk_sys), .rstn(rstn),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op),
  .instr_d(instr_d), .instr_bit(instr_bit), .instr_off(instr_off),
  .next_two_word(next_two_word), .pc(pc), .dmem_rd(dmem_rd), .io_addr(io_addr),
  .io_rdata(io_rdata));
`default_nettype wire
